//--- vqm_manager.sv
// vectored interrupt manager: routing, enable, priority, vector dispatch
// assumes request lines are levels from peripherals on i_ref_clk, and that the
// core pulses i_vec_ack once it has taken the vector
`timescale 1ns/1ns
module vqm_manager
   import vqm_pkg::*;
(
   input  wire logic           i_ref_clk,
   input  wire logic           i_rstn,
   input  wire logic [NCH-1:0] i_irq_src,
   input  wire logic [NCH-1:0] i_chan_en,
   input  wire logic           i_map_wr,
   input  wire logic [CW-1:0]  i_map_chan,
   input  wire logic [CW-1:0]  i_map_src,
   input  wire logic           i_tbl_wr,
   input  wire logic [CW-1:0]  i_tbl_addr,
   input  wire logic [VW-1:0]  i_tbl_data,
   input  wire logic           i_vec_ack,
   output logic                o_irq,
   output logic                o_nmi,
   output logic [VW-1:0]       o_vec_addr,
   output logic [VW-1:0]       o_vec_reg,
   output logic [7:0]          o_index,
   output logic                o_par_err
);

   ////////////////////////////////////////////////////////////////////////////////
   // channel map state
   logic [CW-1:0]  map_q [NCH];
   logic [NCH-1:0] remap_q;
   logic [NCH-1:0] routed;
   logic [NCH-1:0] gated;
   logic [NCH-1:0] pend_q;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         for (int c = 0; c < NCH; c++) begin
            map_q[c] <= CW'(c);
         end
         remap_q <= '0;
      end else if (i_map_wr) begin
         map_q[i_map_chan]   <= i_map_src;
         remap_q[i_map_chan] <= 1'b1;
      end
   end

   // reserved inputs stay dark until software steers a source there
   genvar g;
   for (g = 0; g < NCH; g++) begin : g_route
      assign routed[g] = i_irq_src[map_q[g]] & (remap_q[g] | ~RSVD_MASK[g]);
   end

   // channel 0 ignores its enable: it carries the non-maskable source
   assign gated = routed & {i_chan_en[NCH-1:1], 1'b1} & {1'b0, {(NCH-1){1'b1}}};

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         pend_q <= '0;
      end else begin
         pend_q <= gated;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // priority: lowest channel number wins
   function automatic logic [CW-1:0] lowest(input logic [NCH-1:0] v);
      logic [CW-1:0] r;
      r = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = CW'(i);
         end
      end
      return r;
   endfunction : lowest

   logic          win_any;
   logic [CW-1:0] win_ch;
   logic [CW-1:0] win_entry;

   assign win_any   = |pend_q;
   assign win_ch    = lowest(pend_q);
   assign win_entry = win_any ? (win_ch + 7'h01) : PHANTOM_ENTRY;

   ////////////////////////////////////////////////////////////////////////////////
   // dispatch sequencer
   vqm_state_e    state_q;
   vqm_state_e    state_d;
   logic [CW-1:0] idx_q;
   logic          tbl_rd;
   logic [VW-1:0] tbl_rdata;
   logic          tbl_err;

   assign tbl_rd = (state_q == ST_IDLE);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (win_any) begin
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_d = ST_REQ;
         end
         ST_REQ: begin
            if (i_vec_ack) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         state_q <= ST_IDLE;
         idx_q   <= '0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_IDLE) begin
            idx_q <= win_ch;
         end
      end
   end

   vqm_vec_table #(
      .DW (VW),
      .AW (CW)
   ) u_table (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_wr      (i_tbl_wr),
      .i_waddr   (i_tbl_addr),
      .i_wdata   (i_tbl_data),
      .i_rd      (tbl_rd),
      .i_raddr   (win_entry),
      .o_rdata   (tbl_rdata),
      .o_par_err (tbl_err)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // outputs: direct vector port plus the two software-visible views
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_irq      <= 1'b0;
         o_nmi      <= 1'b0;
         o_vec_addr <= VEC_RST;
         o_vec_reg  <= VEC_RST;
         o_index    <= IDX_NONE;
         o_par_err  <= 1'b0;
      end else begin
         o_nmi     <= pend_q[0];
         o_par_err <= tbl_err;
         if (state_q == ST_FETCH) begin
            o_irq      <= 1'b1;
            o_vec_addr <= tbl_rdata;
            o_vec_reg  <= tbl_rdata;
            o_index    <= {1'b0, idx_q} + 8'h01;
         end else if (state_q == ST_REQ && i_vec_ack) begin
            o_irq <= 1'b0;
         end else if (state_q == ST_IDLE && !win_any) begin
            // nothing pending: software sees the phantom entry
            o_index   <= IDX_NONE;
            o_vec_reg <= tbl_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_pick;
      state_q == ST_IDLE && win_any;
   endsequence

   sequence s_present;
      state_q == ST_FETCH ##1 (o_irq && state_q == ST_REQ);
   endsequence

   irq_dispatch_a: assert property (s_pick |=> s_present)
      else $error("winner not presented two cycles after pick");

   ack_release_a: assert property (state_q == ST_REQ && i_vec_ack |=> !o_irq && state_q == ST_IDLE)
      else $error("irq still high after ack");

   pick_lowest_a: assert property (state_q == ST_IDLE && pend_q[0] && pend_q[3] |=> idx_q == 7'h00)
      else $error("higher channel beat channel zero");

   index_offset_a: assert property ($rose(o_irq) |-> o_index == {1'b0, $past(idx_q)} + 8'h01)
      else $error("index not one above channel");

   chan_last_a: assert property (!pend_q[NCH-1])
      else $error("channel 127 became pending");

   rsvd_quiet_a: assert property (!remap_q[1] |=> !pend_q[1])
      else $error("reserved channel pending without remap");

   disabled_quiet_a: assert property (!i_chan_en[5] |=> !pend_q[5])
      else $error("disabled channel became pending");

   nmi_follow_a: assert property (routed[0] |=> ##1 o_nmi)
      else $error("nmi not raised two cycles after request");

   vec_views_a: assert property (o_irq |-> o_vec_reg == o_vec_addr)
      else $error("vector register differs from vector port");

   parity_read_a: assert property (o_par_err |-> $past(tbl_rd, 2))
      else $error("parity error without table read");

endmodule : vqm_manager

//--- vqm_pkg.sv
// constants for the vectored interrupt manager: channel counts, default map, states
// assumes a single 250 MHz clock and peripherals on that same clock
//
// Functional notes
// - accepts 128 request channels, channels 0..126 routable toward the processor
// - each channel except 0 has its own enable; priority is set by its mapped channel
// - direct vector port hands the winner's routine address to the core
// - software reads either the pending index or the vector register
// - vector table carries parity; errors flagged when entries are read
// - default channel 0 is the error unit's high-level non-maskable interrupt
// - tick timer compares 0..3 default to channels 2..5 in order
// - tick timer overflows use channels 6 and 7, time-base uses 8
// - converter a: event 14, group1 15, group2 28, magnitude 31
// - converter b: event 50, group1 51, group2 57, magnitude 59
// - timer coprocessor a levels 0/1 on channels 10/24
// - timer transfer unit a levels 0/1 on channels 11/25
// - timer coprocessor b levels 0/1 on channels 63/73
// - timer transfer unit b levels 0/1 on channels 65/75
// - buffered serial port a levels 0/1 on channels 12/26
// - buffered serial port b levels 0/1 on channels 37/38
// - buffered serial port c levels 0/1 on channels 53/56
// - plain serial port levels 0/1 on channels 17/30
// - lin serial port levels 0/1 on channels 13/27
// - async serial port b levels 0/1 on channels 64/74
// - can node a: level0 16, level1 29, interface-3 44
// - can node b: level0 35, level1 42, interface-3 46
// - lowest-numbered pending enabled channel wins
// - table entry zero is phantom; channel n at entry n+1; channel 127 unusable
// - per-channel map ports choose which source drives each channel
package vqm_pkg;

   localparam int unsigned NCH      = 128;
   localparam int unsigned CW       = 7;
   localparam int unsigned VW       = 32;
   localparam logic [CW-1:0] LAST_CH = 7'h7F;   // no table entry above it

   // default source index equals default channel; names give the sources
   localparam logic [CW-1:0] SRC_ERR_HIGH     = 7'h00;
   localparam logic [CW-1:0] SRC_TICK_CMP0    = 7'h02;
   localparam logic [CW-1:0] SRC_TICK_OVF0    = 7'h06;
   localparam logic [CW-1:0] SRC_TICK_BASE    = 7'h08;
   localparam logic [CW-1:0] SRC_TCOPA_L0     = 7'h0A;
   localparam logic [CW-1:0] SRC_TTUA_L0      = 7'h0B;
   localparam logic [CW-1:0] SRC_BSPA_L0      = 7'h0C;
   localparam logic [CW-1:0] SRC_LIN_L0       = 7'h0D;
   localparam logic [CW-1:0] SRC_CONVA_EVT    = 7'h0E;
   localparam logic [CW-1:0] SRC_CANA_L0      = 7'h10;
   localparam logic [CW-1:0] SRC_PSP_L0       = 7'h11;
   localparam logic [CW-1:0] SRC_CONVA_MAG    = 7'h1F;
   localparam logic [CW-1:0] SRC_CANB_L0      = 7'h23;
   localparam logic [CW-1:0] SRC_BSPB_L0      = 7'h25;
   localparam logic [CW-1:0] SRC_CONVB_EVT    = 7'h32;
   localparam logic [CW-1:0] SRC_BSPC_L0      = 7'h35;
   localparam logic [CW-1:0] SRC_CONVB_MAG    = 7'h3B;
   localparam logic [CW-1:0] SRC_TCOPB_L0     = 7'h3F;
   localparam logic [CW-1:0] SRC_ASPB_L0      = 7'h40;
   localparam logic [CW-1:0] SRC_TTUB_L0      = 7'h41;

   // channels with no source in the default map
   localparam logic [NCH-1:0] RSVD_MASK =
      128'hFFFF_0000_00D0_F1F8_4411_0201_0004_0002;

   localparam logic [CW-1:0] PHANTOM_ENTRY = 7'h00;
   localparam logic [VW-1:0] VEC_RST       = 32'h0000_0000;
   localparam logic [7:0]    IDX_NONE      = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FETCH = 3'b010,
      ST_REQ   = 3'b100
   } vqm_state_e;

endpackage : vqm_pkg

//--- vqm_vec_table.sv
// vector table with one parity bit per word
// assumes a single writer and one registered read port on the same clock
`timescale 1ns/1ns
module vqm_vec_table
   import vqm_pkg::*;
#(
   parameter int unsigned DW = 32,
   parameter int unsigned AW = 7
) (
   input  wire logic          i_ref_clk,
   input  wire logic          i_rstn,
   input  wire logic          i_wr,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic          i_rd,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata,
   output logic               o_par_err
);

   ////////////////////////////////////////////////////////////////////////////////
   // storage holds data plus even parity; not reset, like a real ram
   logic [DW:0] mem [2**AW];
   logic [DW:0] rd_word;

   assign rd_word = mem[i_raddr];

   always_ff @(posedge i_ref_clk) begin
      if (i_wr) begin
         mem[i_waddr] <= {^i_wdata, i_wdata};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_rdata   <= '0;
         o_par_err <= 1'b0;
      end else begin
         if (i_rd) begin
            o_rdata <= rd_word[DW-1:0];
         end
         o_par_err <= i_rd & (^rd_word);
      end
   end

endmodule : vqm_vec_table

//--- vqm_core_model.sv
// core-side model: takes each dispatched vector and acknowledges it
// assumes manager outputs have settled by the falling edge
`timescale 1ns/1ns
module vqm_core_model (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_irq,
   input  wire logic [31:0] i_vec_addr,
   input  wire logic [1:0]  i_slow,
   output logic             o_vec_ack,
   output logic [31:0]      o_taken
);
   logic [1:0] wait_q;
   ////////////////////////////////////////////////////////////////
   // ack after i_slow cycles; one-cycle pulse, so never held over
   always @(negedge i_ref_clk) begin
      if (!i_rstn || o_vec_ack) begin
         o_vec_ack <= 1'b0;
         wait_q    <= 2'h0;
      end else if (i_irq && wait_q == i_slow) begin
         o_vec_ack <= 1'b1;
         o_taken   <= i_vec_addr;
      end else if (i_irq) begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule : vqm_core_model

//--- vqm_manager_tb.sv
// self-checking bench for the vectored interrupt manager
// assumes the core model acks every dispatch; inputs move on falling edges
`timescale 1ns/1ns
module vqm_manager_tb;
   import vqm_pkg::*;
   logic           i_ref_clk = 1'b0;
   logic           i_rstn    = 1'b0;
   logic [NCH-1:0] src       = '0;
   logic [NCH-1:0] en        = ~128'h1;
   logic           map_wr    = 1'b0;
   logic           tbl_wr    = 1'b0;
   logic [CW-1:0]  map_chan  = '0;
   logic [CW-1:0]  map_src   = '0;
   logic [CW-1:0]  tbl_addr  = '0;
   logic [VW-1:0]  tbl_data  = '0;
   logic [1:0]     slow      = 2'h0;
   logic [31:0]    seed      = 32'h0000_5BDE;
   logic [VW-1:0]  vec_addr, vec_reg, taken;
   logic           ack, irq, nmi, par_err;
   logic [7:0]     index;
   logic [VW-1:0]  tbl [NCH];
   int             n_errors  = 0;
   int             n_tests   = 0;
   localparam int DEF_CH [42] = '{0, 2, 3, 4, 5, 6, 7, 8, 10, 11, 12, 13, 14, 15, 16, 17,
      24, 25, 26, 27, 28, 29, 30, 31, 35, 37, 38, 42, 44, 46, 50, 51, 53, 56, 57, 59,
      63, 64, 65, 73, 74, 75};

   initial begin
      forever #2 i_ref_clk = ~i_ref_clk;
   end

   vqm_manager dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_irq_src(src),
      .i_chan_en(en), .i_map_wr(map_wr), .i_map_chan(map_chan), .i_map_src(map_src),
      .i_tbl_wr(tbl_wr), .i_tbl_addr(tbl_addr), .i_tbl_data(tbl_data),
      .i_vec_ack(ack), .o_irq(irq), .o_nmi(nmi), .o_vec_addr(vec_addr),
      .o_vec_reg(vec_reg), .o_index(index), .o_par_err(par_err));
   vqm_core_model core (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_irq(irq),
      .i_vec_addr(vec_addr), .i_slow(slow), .o_vec_ack(ack), .o_taken(taken));

   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic print_verdict();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   // bounded wait; a hang ends the run
   task automatic wait_irq(input logic lvl);
      int k;
      k = 0;
      while (irq !== lvl && k < 60) begin
         @(negedge i_ref_clk);
         k++;
      end
      if (irq !== lvl) begin
         chk(32'(irq), 32'(lvl), "irq timeout");
         print_verdict();
      end
   endtask : wait_irq

   // line is dropped as soon as seen, else it would dispatch again
   task automatic serve(input int ch, input int s);
      // set while irq is low so the core model never samples it mid-change
      slow = 2'(xs());
      wait_irq(1'b1);
      chk(32'(index), 32'(ch + 1), "index");
      chk(vec_addr, tbl[ch+1], "vector");
      chk(vec_reg, tbl[ch+1], "vector reg");
      chk(32'(nmi), 32'(ch == 0), "nmi");
      chk(32'(par_err), 32'h0, "parity");
      src[s] = 1'b0;
      wait_irq(1'b0);
      chk(taken, tbl[ch+1], "taken");
   endtask : serve

   task automatic quiet(input int cyc);
      int hi;
      hi = 0;
      repeat (cyc) begin
         @(negedge i_ref_clk);
         if (irq !== 1'b0) hi++;
      end
      chk(32'(hi), 32'h0, "quiet");
   endtask : quiet

   task automatic map(input int c, input int s);
      map_wr   = 1'b1;
      map_chan = CW'(c);
      map_src  = CW'(s);
      @(negedge i_ref_clk);
      map_wr   = 1'b0;
   endtask : map

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge i_ref_clk);
      i_rstn = 1'b1;
      for (int a = 0; a < NCH; a++) begin
         tbl[a]   = xs();
         tbl_wr   = 1'b1;
         tbl_addr = CW'(a);
         tbl_data = tbl[a];
         @(negedge i_ref_clk);
      end
      tbl_wr = 1'b0;
      quiet(4);
      chk(32'(index), 32'h0, "idle index");
      chk(vec_reg, tbl[0], "phantom");
      // channel 0 with its enable low still goes through
      foreach (DEF_CH[i]) begin
         src[DEF_CH[i]] = 1'b1;
         serve(DEF_CH[i], DEF_CH[i]);
      end
      // round 0 raises every live channel at once
      for (int r = 0; r < 8; r++) begin
         en  = {xs(), xs(), xs(), xs()};
         src = {xs(), xs(), xs(), xs()} & ~RSVD_MASK;
         if (r == 0) src = ~RSVD_MASK;
         for (int c = 0; c < NCH; c++)
            if (src[c] && (en[c] || c == 0)) serve(c, c);
         quiet(8);
         src = '0;
      end
      en     = '1;
      src[1] = 1'b1;
      quiet(8);
      map(1, 1);
      serve(1, 1);
      en[40]  = 1'b0;
      src[40] = 1'b1;
      map(9, 40);
      serve(9, 40);
      en[5]  = 1'b0;
      src[5] = 1'b1;
      map(127, 5);
      quiet(8);
      print_verdict();
   end
endmodule : vqm_manager_tb
